/* File: hdl/ulsu_pkg.sv */
/*
 Shared constants and carriers for the UART line status block: register
 byte offsets, status bit positions, control layout and reset value,
 buffer depths and bit timing.
 Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package ulsu_pkg;

	localparam logic [3:0] ADDR_DATA    = 4'h0;
	localparam logic [3:0] ADDR_STATUS  = 4'h4;
	localparam logic [3:0] ADDR_CONTROL = 4'h8;

	localparam int BIT_FIFO_ERR      = 7;
	localparam int BIT_TX_ALL_EMPTY  = 6;
	localparam int BIT_TX_HOLD_EMPTY = 5;
	localparam int BIT_BREAK         = 4;
	localparam int BIT_FRAMING       = 3;

	localparam logic [7:0] CONTROL_RESET = 8'hA0;
	localparam logic [7:0] BREAK_CHAR    = 8'h00;

	localparam int RX_DEPTH = 32;
	localparam int TX_DEPTH = 32;

	localparam int CLK_HZ    = 25000000;
	localparam int BAUD_RATE = 115200;
	localparam int BIT_DIV   = CLK_HZ / BAUD_RATE;

	// Serial frame sent by the shifter: start, eight data, one stop
	localparam logic [3:0] TX_FRAME_BITS = 4'hA;

	typedef struct packed {
		logic [7:0] data;
		logic       parity_err;
		logic       frame_err;
		logic       brk;
	} ulsu_rx_char_t;

	typedef struct packed {
		logic [3:0] frame_bits;
		logic [1:0] unused;
		logic       tx_irq_en;
		logic       fifo_en;
	} ulsu_control_t;

endpackage

/* File: hdl/ulsu_tx_shifter.sv */
/*
 Transmit shift register: takes one byte, holds the line high until the
 next bit tick, then sends start, data LSB first, stop, one bit per tick.
 Assumes a one-cycle bit tick from a divider on the same clock.
*/
module ulsu_tx_shifter (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       bit_tick,
	input  wire logic       load,
	input  wire logic [7:0] load_data,
	output logic            busy,
	output logic            serial_out
);

	logic [10:0] shreg;
	logic [3:0]  left;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			shreg <= 11'h7FF;
			left  <= 4'h0;
		end else if (load && left == 4'h0) begin
			// Idle lead bit: the tick runs free, so without it the
			// start bit could be cut short by the tick phase
			shreg <= {1'b1, load_data, 1'b0, 1'b1};
			left  <= ulsu_pkg::TX_FRAME_BITS + 4'h1;
		end else if (bit_tick && left != 4'h0) begin
			shreg <= {1'b1, shreg[10:1]};
			left  <= left - 4'h1;
		end
	end

	assign busy       = (left != 4'h0);
	assign serial_out = shreg[0];

endmodule

/* File: hdl/ulsu_line_status.sv */
/*
 UART line status upper bits with the receive buffer, transmit buffer,
 transmit shifter and break detector that feed them, behind an
 Avalon-MM slave with one wait state.
 Assumes a receiver outside that delivers whole characters with their
 parity and framing error flags as one-cycle strobes, and a serial
 receive line synchronous to CLK_SYS. The parity, overrun and data
 ready status bits are not kept here and read 0. Changing the FIFO
 mode does not flush either buffer, so software should let both
 empty first.
*/
// Implementation choices: the register offsets and the Avalon-MM slave port.
module ulsu_line_status #(
	parameter int RX_DEPTH = ulsu_pkg::RX_DEPTH,
	parameter int TX_DEPTH = ulsu_pkg::TX_DEPTH,
	parameter int BIT_DIV  = ulsu_pkg::BIT_DIV
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_B,
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic        RX_SERIAL,
	input  wire logic        RX_CHAR_VALID,
	input  wire logic [7:0]  RX_CHAR_DATA,
	input  wire logic        RX_CHAR_PARITY_ERR,
	input  wire logic        RX_CHAR_FRAME_ERR,
	output logic             TX_SERIAL,
	output logic             TX_EMPTY_IRQ
);

	// Counts need one more value than the depth, pointers do not
	localparam int RXP = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
	localparam int RXC = $clog2(RX_DEPTH + 1);
	localparam int TXP = (TX_DEPTH > 1) ? $clog2(TX_DEPTH) : 1;
	localparam int TXC = $clog2(TX_DEPTH + 1);
	localparam int DVW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;

	// Bus slave: one wait state, side effects at the accepting edge.
	// ack drops after each answer, so a strobe held high starts a new
	// access rather than repeating the side effects of the last one.
	logic                    ack;
	logic [31:0]             next_readdata;
	ulsu_pkg::ulsu_control_t control;

	wire req        = AVS_READ | AVS_WRITE;
	wire fire       = req & ack;
	wire lane0      = AVS_BYTEENABLE[0];
	wire hit_data   = (AVS_ADDRESS == ulsu_pkg::ADDR_DATA);
	wire hit_status = (AVS_ADDRESS == ulsu_pkg::ADDR_STATUS);
	wire hit_ctl    = (AVS_ADDRESS == ulsu_pkg::ADDR_CONTROL);
	wire fifo_en    = control.fifo_en;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			ack          <= 1'b0;
			AVS_READDATA <= 32'h0000_0000;
		end else begin
			ack          <= req & ~ack;
			AVS_READDATA <= next_readdata;
		end
	end

	assign AVS_WAITREQUEST = req & ~ack;

	wire ctl_write = fire & AVS_WRITE & hit_ctl & lane0;

	// Only the low lane is kept; the upper lanes of the word are ignored
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			control <= ulsu_pkg::CONTROL_RESET;
		end else if (ctl_write) begin
			control <= AVS_WRITEDATA[7:0];
		end
	end

	// Bit tick divider shared by break detector and shifter
	// One pulse every BIT_DIV clocks; it never pauses between frames.
	logic [DVW-1:0] div_cnt;
	wire div_wrap = (div_cnt == DVW'(BIT_DIV - 1));

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_wrap ? '0 : div_cnt + DVW'(1);
		end
	end

	wire bit_tick = div_wrap;

	// Break detector; the tick phase is free running, so the low time
	// is measured to within one bit of the frame time.
	logic [3:0] low_bits;
	wire low_step = bit_tick & ~RX_SERIAL & (low_bits < control.frame_bits);

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			low_bits <= 4'h0;
		end else if (RX_SERIAL) begin
			low_bits <= 4'h0;
		end else if (low_step) begin
			low_bits <= low_bits + 4'h1;
		end
	end

	wire break_event = low_step & (low_bits == control.frame_bits - 4'h1);

	// Receive buffer; one slot deep outside FIFO mode, where it acts as
	// the holding register. Each slot keeps its own error bits, so the
	// summary flag follows the data as it is read out.
	ulsu_pkg::ulsu_rx_char_t rx_mem [RX_DEPTH];
	ulsu_pkg::ulsu_rx_char_t rx_in;
	logic [RX_DEPTH-1:0]     rx_occ;
	logic [RX_DEPTH-1:0]     rx_slot_err;
	logic [RXP-1:0]          rx_wr_ptr;
	logic [RXP-1:0]          rx_rd_ptr;
	logic [RXC-1:0]          rx_count;

	wire [RXC-1:0] rx_limit = fifo_en ? RXC'(RX_DEPTH) : RXC'(1);
	wire rx_full  = (rx_count >= rx_limit);
	wire rx_empty = (rx_count == '0);
	// A break wins over a character arriving in the same cycle
	wire rx_push  = (RX_CHAR_VALID | break_event) & ~rx_full;
	wire rx_pop   = fire & AVS_READ & hit_data & ~rx_empty;

	assign rx_in.data       = break_event ? ulsu_pkg::BREAK_CHAR
	                                      : RX_CHAR_DATA;
	assign rx_in.parity_err = ~break_event & RX_CHAR_PARITY_ERR;
	assign rx_in.frame_err  = ~break_event & RX_CHAR_FRAME_ERR;
	assign rx_in.brk        = break_event;

	// Write and read pointers meet only when empty or full, and then
	// the pop or the push is refused, so no slot sees both at once.
	genvar gi;
	generate
		for (gi = 0; gi < RX_DEPTH; gi++) begin : g_rx_slot
			wire wr_here = rx_push & (rx_wr_ptr == RXP'(gi));
			wire rd_here = rx_pop & (rx_rd_ptr == RXP'(gi));

			always_ff @(posedge CLK_SYS) begin
				if (!RST_B) begin
					rx_occ[gi] <= 1'b0;
					rx_mem[gi] <= '0;
				end else if (wr_here) begin
					rx_occ[gi] <= 1'b1;
					rx_mem[gi] <= rx_in;
				end else if (rd_here) begin
					rx_occ[gi] <= 1'b0;
				end
			end

			assign rx_slot_err[gi] = rx_occ[gi] & (rx_mem[gi].parity_err
			                       | rx_mem[gi].frame_err | rx_mem[gi].brk);
		end
	endgenerate

	wire [RXP-1:0] rx_wr_next = (rx_wr_ptr == RXP'(RX_DEPTH - 1))
	                          ? '0 : rx_wr_ptr + RXP'(1);
	wire [RXP-1:0] rx_rd_next = (rx_rd_ptr == RXP'(RX_DEPTH - 1))
	                          ? '0 : rx_rd_ptr + RXP'(1);

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			rx_wr_ptr <= '0;
			rx_rd_ptr <= '0;
			rx_count  <= '0;
		end else begin
			if (rx_push)
				rx_wr_ptr <= rx_wr_next;
			if (rx_pop)
				rx_rd_ptr <= rx_rd_next;
			rx_count <= rx_count + RXC'(rx_push) - RXC'(rx_pop);
		end
	end

	// Transmit buffer; one slot deep outside FIFO mode, where it is the
	// holding register. A write to a full buffer is dropped, not queued.
	logic [7:0]     tx_mem [TX_DEPTH];
	logic [TXP-1:0] tx_wr_ptr;
	logic [TXP-1:0] tx_rd_ptr;
	logic [TXC-1:0] tx_count;
	logic           shifter_busy;

	wire [TXC-1:0] tx_limit = fifo_en ? TXC'(TX_DEPTH) : TXC'(1);
	wire tx_empty = (tx_count == '0);
	wire tx_load  = fire & AVS_WRITE & hit_data & lane0
	              & (tx_count < tx_limit);
	// With the shifter idle the move follows the load by one cycle.
	// Move to shifter empties holding
	wire tx_move  = ~tx_empty & ~shifter_busy;

	wire [TXP-1:0] tx_wr_next = (tx_wr_ptr == TXP'(TX_DEPTH - 1))
	                          ? '0 : tx_wr_ptr + TXP'(1);
	wire [TXP-1:0] tx_rd_next = (tx_rd_ptr == TXP'(TX_DEPTH - 1))
	                          ? '0 : tx_rd_ptr + TXP'(1);

	always_ff @(posedge CLK_SYS) begin
		if (tx_load)
			tx_mem[tx_wr_ptr] <= AVS_WRITEDATA[7:0];
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			tx_wr_ptr <= '0;
			tx_rd_ptr <= '0;
			tx_count  <= '0;
		end else begin
			if (tx_load)
				tx_wr_ptr <= tx_wr_next;
			if (tx_move)
				tx_rd_ptr <= tx_rd_next;
			tx_count <= tx_count + TXC'(tx_load) - TXC'(tx_move);
		end
	end

	// The shifter counts as busy from the move, before its start bit
	ulsu_tx_shifter u_shifter (
		.clk        (CLK_SYS),
		.rst_b      (RST_B),
		.bit_tick   (bit_tick),
		.load       (tx_move),
		.load_data  (tx_mem[tx_rd_ptr]),
		.busy       (shifter_busy),
		.serial_out (TX_SERIAL)
	);

	// Status flags
	logic break_flag;
	wire  status_read = fire & AVS_READ & hit_status;

	// Cleared at the accepting edge of any status read, which reports the flag as it was in its first cycle;
	// a break in the accepting cycle is kept for the next read.
	// Sticky break, set wins
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			break_flag <= 1'b0;
		end else if (break_event) begin
			break_flag <= 1'b1;
		end else if (status_read) begin
			break_flag <= 1'b0;
		end
	end

	// Outside FIFO mode the summary reads 0.
	// Summary clears with last error
	wire fifo_err_flag = fifo_en & (|rx_slot_err);
	wire tx_all_empty  = tx_empty & ~shifter_busy;
	wire tx_hold_empty = tx_empty;
	wire framing_flag  = ~rx_empty & rx_mem[rx_rd_ptr].frame_err;

	logic [7:0] line_status;

	always_comb begin
		line_status                              = 8'h00;
		line_status[ulsu_pkg::BIT_FIFO_ERR]      = fifo_err_flag;
		line_status[ulsu_pkg::BIT_TX_ALL_EMPTY]  = tx_all_empty;
		line_status[ulsu_pkg::BIT_TX_HOLD_EMPTY] = tx_hold_empty;
		line_status[ulsu_pkg::BIT_BREAK]         = break_flag;
		line_status[ulsu_pkg::BIT_FRAMING]       = framing_flag;
	end

	wire [7:0] rx_top = rx_empty ? 8'h00 : rx_mem[rx_rd_ptr].data;

	// Read data is captured in the first cycle of a read, so the master
	// sees the state from the start of its request.
	wire        rd_first = AVS_READ & ~ack;
	wire [31:0] rd_data  = {24'h000000, rx_top};
	wire [31:0] rd_stat  = {24'h000000, line_status};
	wire [31:0] rd_ctl   = {24'h000000, control};

	assign next_readdata = ~rd_first  ? 32'h0000_0000 :
	                       hit_data   ? rd_data :
	                       hit_status ? rd_stat :
	                       hit_ctl    ? rd_ctl :
	                                    32'h0000_0000;

	assign TX_EMPTY_IRQ = control.tx_irq_en & tx_hold_empty;

endmodule

/* File: sim/ulsu_checker.sv */
/* Port assertions for the line status block.
 Bound to ulsu_line_status; expects BIT_DIV handed on by the bind. */
module ulsu_checker #(
	parameter int BIT_DIV = 4
) (
	input wire logic        CLK_SYS,
	input wire logic        RST_B,
	input wire logic [3:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0]  AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        RX_SERIAL,
	input wire logic        RX_CHAR_VALID,
	input wire logic [7:0]  RX_CHAR_DATA,
	input wire logic        RX_CHAR_PARITY_ERR,
	input wire logic        RX_CHAR_FRAME_ERR,
	input wire logic        TX_SERIAL,
	input wire logic        TX_EMPTY_IRQ
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	logic        dirty;
	logic        brk_ok;
	logic [15:0] low_run;
	wire logic   st_rd = AVS_READ && !AVS_WAITREQUEST &&
		AVS_ADDRESS == ulsu_pkg::ADDR_STATUS;
	wire logic   err_in = RX_CHAR_VALID &&
		(RX_CHAR_PARITY_ERR || RX_CHAR_FRAME_ERR);
	// One bit of slack: the break tick phase runs free
	wire logic   long_low = low_run >= 16'(9 * BIT_DIV - 1);
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			dirty   <= 1'b0;
			brk_ok  <= 1'b0;
			low_run <= 16'h0000;
		end else begin
			dirty   <= dirty || err_in || !RX_SERIAL;
			brk_ok  <= brk_ok || long_low;
			low_run <= RX_SERIAL ? 16'h0000 : low_run + 16'h0001;
		end
	end
	sequence req_rise;
		$rose(AVS_READ || AVS_WRITE);
	endsequence
	sequence one_wait;
		AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
	endsequence
	AST_WAIT_ONE: assert property (req_rise |-> one_wait)
		else $error("waitrequest not one cycle");
	AST_IRQ_HOLD: assert property (
		st_rd && $past(TX_EMPTY_IRQ) |-> AVS_READDATA[5])
		else $error("interrupt without holding empty");
	AST_ALL_EMPTY: assert property (
		st_rd && AVS_READDATA[6] |-> AVS_READDATA[5] && $past(TX_SERIAL))
		else $error("all empty while transmitting");
	AST_HIGH_ZERO: assert property (st_rd |->
		AVS_READDATA[31:8] == 24'h0 && AVS_READDATA[2:0] == 3'h0)
		else $error("status unused bits not zero");
	AST_CLEAN_ERR: assert property (
		st_rd && !dirty |-> !AVS_READDATA[7])
		else $error("error summary with no cause");
	AST_BREAK_TIME: assert property (
		st_rd && AVS_READDATA[4] |-> brk_ok)
		else $error("break flag before a frame time low");
	AST_TX_RESET_IDLE: assert property (
		$rose(RST_B) |-> TX_SERIAL[*2])
		else $error("transmit line not idle after reset");
	AST_START_BIT: assert property ($fell(TX_SERIAL) |-> !TX_SERIAL[*4])
		else $error("start bit shorter than a bit time");
endmodule
bind ulsu_line_status ulsu_checker #(.BIT_DIV(BIT_DIV)) ulsu_checker_inst (
	.CLK_SYS, .RST_B, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
	.AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .RX_SERIAL,
	.RX_CHAR_VALID, .RX_CHAR_DATA, .RX_CHAR_PARITY_ERR, .RX_CHAR_FRAME_ERR,
	.TX_SERIAL, .TX_EMPTY_IRQ
);

/* File: sim/ulsu_host_model.sv */
/* Host CPU model: Avalon-MM master, one request at a time, plus the
 watcher that checks read data against queued notes.
 Assumes tb holds the counters bad_count and tests_run. */
module ulsu_host_model (
	input  wire logic        clk,
	input  wire logic        waitreq,
	input  wire logic [31:0] rdata,
	output logic             rd,
	output logic             wr,
	output logic [3:0]       addr,
	output logic [31:0]      wdata,
	output logic [3:0]       be
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] exp_q[$];
	logic [63:0] note;
	initial begin
		rd = 1'b0;
		wr = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		be = 4'h0;
	end
	// Request held until the edge that sees waitrequest low
	task automatic acc(input logic w, input logic [3:0] a,
		input logic [7:0] d, input logic [63:0] em, output logic [31:0] got);
		if (!w) exp_q.push_back(em);
		addr <= a;
		wdata <= {24'h0, d};
		be <= 4'hF;
		rd <= !w;
		wr <= w;
		// No cycle count assumed: only the bench timeout ends a wait
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		if (rd && waitreq === 1'b0) begin
			note = exp_q.pop_front();
			tb.tests_run++;
			if ((rdata & note[31:0]) !== (note[63:32] & note[31:0])) begin
				tb.bad_count++;
				$display("CHECK FAILED at %0t: got %h expected %h",
					$time, rdata, note[63:32]);
			end
		end
	end
endmodule

/* File: sim/tb.sv */
/* Self-checking bench for the line status block.
 Assumes the checker is bound and the host model checks all reads. */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int         DIV = 4;
	localparam logic [3:0] A_D = ulsu_pkg::ADDR_DATA;
	localparam logic [3:0] A_S = ulsu_pkg::ADDR_STATUS;
	localparam logic [3:0] A_C = ulsu_pkg::ADDR_CONTROL;
	logic        clk_sys, rst_b, rx_serial, rx_valid, rx_perr, rx_ferr;
	logic        rd_b, wr_b, wait_b, tx_serial, tx_irq;
	logic [7:0]  rx_data;
	logic [3:0]  addr, be;
	logic [31:0] wd, rdat, got;
	int          bad_count, tests_run, cyc, n;
	ulsu_host_model ulsu_host_model_inst (.clk(clk_sys), .waitreq(wait_b),
		.rdata(rdat), .rd(rd_b), .wr(wr_b), .addr(addr), .wdata(wd), .be(be));
	ulsu_line_status #(.BIT_DIV(DIV)) ulsu_line_status_inst (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .AVS_ADDRESS(addr),
		.AVS_READ(rd_b), .AVS_WRITE(wr_b), .AVS_WRITEDATA(wd),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_b),
		.RX_SERIAL(rx_serial), .RX_CHAR_VALID(rx_valid),
		.RX_CHAR_DATA(rx_data), .RX_CHAR_PARITY_ERR(rx_perr),
		.RX_CHAR_FRAME_ERR(rx_ferr), .TX_SERIAL(tx_serial),
		.TX_EMPTY_IRQ(tx_irq));
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		ulsu_host_model_inst.acc(1'b1, a, d, 64'h0, got);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
		ulsu_host_model_inst.acc(1'b0, a, 8'h00, {e, m}, got);
	endtask
	task automatic drain();
		n = 0;
		do begin
			rd(A_S, 32'h0, 32'h0);
			n++;
		end while (got[6] !== 1'b1 && n < 200);
		tests_run++;
		if (got[6] !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h",
				$time, got[6], 1'b1);
		end
	endtask
	// Looked at mid-cycle, where the combinational output has settled
	task automatic chk_irq(input logic e);
		@(negedge clk_sys);
		tests_run++;
		if (tx_irq !== e) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h",
				$time, tx_irq, e);
		end
		@(posedge clk_sys);
	endtask
	task automatic push(input logic [7:0] d, input logic p, f);
		rx_data <= d;
		rx_perr <= p;
		rx_ferr <= f;
		rx_valid <= 1'b1;
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic line_low(input int cycles);
		rx_serial <= 1'b0;
		repeat (cycles) @(posedge clk_sys);
		rx_serial <= 1'b1;
		@(posedge clk_sys);
	endtask
	task automatic wrap_up();
		$display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Long enough for all tests with a wide margin
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			wrap_up();
		end
	end
	initial begin
		{rst_b, rx_valid, rx_perr, rx_ferr, rx_data} = 12'h000;
		rx_serial = 1'b1;
		void'($urandom(32'h5421));
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		rd(A_S, 32'h60, 32'hFF);
		chk_irq(1'b0);
		rd(A_C, 32'hA0, 32'hFF);
		rd(4'hC, 32'h0, 32'hFFFFFFFF);
		wr(A_S, 8'hFF);
		rd(A_S, 32'h60, 32'hFF);
		$display("test 1 done: reset values and read-only status");
		// Holding register handover and its interrupt request
		wr(A_C, 8'hA2);
		chk_irq(1'b1);
		wr(A_D, 8'($urandom));
		rd(A_S, 32'h20, 32'h60);
		wr(A_D, 8'($urandom));
		rd(A_S, 32'h00, 32'h60);
		chk_irq(1'b0);
		drain();
		chk_irq(1'b1);
		$display("test 2 done: single holding register");
		// Transmit buffer
		wr(A_C, 8'hA1);
		for (int i = 0; i < 3; i++) wr(A_D, 8'($urandom));
		rd(A_S, 32'h00, 32'h60);
		chk_irq(1'b0);
		drain();
		rd(A_S, 32'h60, 32'h60);
		$display("test 3 done: transmit buffer");
		// Error summary and top framing flag
		push(8'h11, 1'b0, 1'b0);
		push(8'h22, 1'b1, 1'b0);
		push(8'h33, 1'b0, 1'b1);
		rd(A_S, 32'h80, 32'h88);
		rd(A_D, 32'h11, 32'hFF);
		rd(A_S, 32'h80, 32'h88);
		rd(A_D, 32'h22, 32'hFF);
		rd(A_S, 32'h88, 32'h88);
		rd(A_D, 32'h33, 32'hFF);
		rd(A_S, 32'h00, 32'h88);
		$display("test 4 done: receive error flags");
		// Break detection
		line_low(5 * DIV);
		rd(A_S, 32'h00, 32'h90);
		line_low(30 * DIV);
		rd(A_S, 32'h90, 32'h90);
		rd(A_S, 32'h80, 32'h90);
		rd(A_D, 32'h00, 32'hFF);
		rd(A_S, 32'h00, 32'h90);
		$display("test 5 done: break detection");
		wrap_up();
	end
endmodule
